/* src/dac_host_consts.svh */
// Named constants of the converter host controller: register offsets, fields, timing.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register port.
`ifndef DAC_HOST_CONSTS_SVH
`define DAC_HOST_CONSTS_SVH
`define DAC_ADR_W        8
`define DAC_OFS_DATA     8'h00
`define DAC_OFS_CMD      8'h04
`define DAC_OFS_CTRL     8'h08
`define DAC_OFS_STATUS   8'h0C
`define DAC_OFS_RDATA    8'h10
`define DAC_CMD_CHAN_LSB 0
`define DAC_CMD_OP_LSB   2
`define DAC_CTRL_PD_N    0
`define DAC_CTRL_EN      1
`define DAC_STAT_BUSY    0
`define DAC_STAT_VALID   1
`define DAC_CLK_NS       25
`define DAC_PD_EXIT_NS   5000
`define DAC_PD_EXIT_CYC  ((`DAC_PD_EXIT_NS + `DAC_CLK_NS - 1) / `DAC_CLK_NS)
`define DAC_SETUP_CYC    2
`define DAC_STROBE_CYC   2
`define DAC_SYNC_CYC     2
`define DAC_RECOV_CYC    2
`define DAC_CNT_W        8
`endif

/* src/dac_host_ctrl.sv */
// Host controller for a quad 16-bit parallel converter, driven by Wishbone registers.
// Assumes a 40 MHz clock, a synchronous active-high reset and a converter on the pins.
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "dac_host_consts.svh"

module dac_host_ctrl
   import dac_host_pkg::*;
#(
   parameter logic [7:0] PD_EXIT_CYC = 8'(`DAC_PD_EXIT_CYC),
   parameter logic [7:0] SETUP_CYC   = 8'(`DAC_SETUP_CYC),
   parameter logic [7:0] STROBE_CYC  = 8'(`DAC_STROBE_CYC),
   parameter logic [7:0] RECOV_CYC   = 8'(`DAC_RECOV_CYC)
)
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [`DAC_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   output dac_ctl_t                    ctl_o,
   output logic      [15:0]            data_o,
   output logic                        data_oe_o,
   input  wire logic [15:0]            data_i
);

   host_state_t state_reg;
   host_state_t state_next;

   logic        req;
   logic        wr;
   logic        busy;
   logic [7:0]  read_hold;

   // A read keeps chip select low long enough for the bus to cross both sync stages.
   assign read_hold = 8'(STROBE_CYC + 8'(`DAC_SYNC_CYC));

   // A new request is one the slave has not yet answered; ack drops the next cycle.
   assign req  = wb_cyc_i && wb_stb_i && !state_reg.ack;
   assign wr   = req && wb_we_i;
   assign busy = (state_reg.seq != ST_IDLE);

   // Register read mux; unmapped offsets read as zero.
   function automatic logic [31:0] read_mux(input host_state_t s, input logic [7:0] adr);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (adr)
         `DAC_OFS_DATA:   v[15:0] = s.wdata;
         `DAC_OFS_CMD:    v[4:0]  = {s.op, s.chan};
         `DAC_OFS_CTRL:   v[1:0]  = {s.en, s.ctl.power_down_n};
         `DAC_OFS_STATUS: v[1:0]  = {s.valid, s.seq != ST_IDLE};
         `DAC_OFS_RDATA:  v[15:0] = s.rbuf;
         default:         v       = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Whole next-state computation: bus slave, pin sequencer, power-down timer.
   always_comb
   begin
      state_next       = state_reg;
      state_next.ack   = req;
      state_next.sync1 = data_i;
      state_next.sync2 = state_reg.sync1;

      if (req && !wb_we_i)
      begin
         state_next.rdat = read_mux(state_reg, wb_adr_i);
      end

      // Write data register; the code passes through as plain unsigned binary.
      if (wr && wb_adr_i == `DAC_OFS_DATA)
      begin
         if (wb_sel_i[0])
         begin
            state_next.wdata[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1])
         begin
            state_next.wdata[15:8] = wb_dat_i[15:8];
         end
      end

      // Control register: interface enable and the power-down pin level.
      if (wr && wb_adr_i == `DAC_OFS_CTRL && wb_sel_i[0])
      begin
         state_next.en               = wb_dat_i[`DAC_CTRL_EN];
         state_next.ctl.power_down_n = wb_dat_i[`DAC_CTRL_PD_N];
      end

      // Leaving power-down restarts the exit wait; the output registers are not touched.
      if (!state_reg.ctl.power_down_n)
      begin
         state_next.valid  = 1'b0;
         state_next.pd_cnt = PD_EXIT_CYC;
      end
      else if (state_reg.pd_cnt != 8'h00)
      begin
         state_next.pd_cnt = state_reg.pd_cnt - 8'h01;
         state_next.valid  = 1'b0;
      end
      else
      begin
         state_next.valid = 1'b1;
      end

      // Pin sequencer; a command written while busy or disabled is dropped.
      unique case (state_reg.seq)
         ST_IDLE:
         begin
            if (wr && wb_adr_i == `DAC_OFS_CMD && wb_sel_i[0] && state_reg.en)
            begin
               state_next.chan                = wb_dat_i[`DAC_CMD_CHAN_LSB +: 2];
               state_next.op                  = dac_op_t'(wb_dat_i[`DAC_CMD_OP_LSB +: 3]);
               state_next.ctl.channel_sel_msb = wb_dat_i[`DAC_CMD_CHAN_LSB + 1];
               state_next.ctl.channel_sel_lsb = wb_dat_i[`DAC_CMD_CHAN_LSB];
               state_next.cnt                 = SETUP_CYC;
               unique case (dac_op_t'(wb_dat_i[`DAC_CMD_OP_LSB +: 3]))
                  OP_WRITE:
                  begin
                     state_next.dout   = state_reg.wdata;
                     state_next.doe    = 1'b1;
                     state_next.ctl.rw = 1'b0;
                     state_next.seq    = ST_SETUP;
                  end
                  OP_READ:
                  begin
                     state_next.doe    = 1'b0;
                     state_next.ctl.rw = 1'b1;
                     state_next.seq    = ST_SETUP;
                  end
                  OP_LOAD:
                  begin
                     state_next.ctl.load_output_strobe = 1'b1;
                     state_next.cnt                    = STROBE_CYC;
                     state_next.seq                    = ST_STROBE;
                  end
                  OP_RESET:
                  begin
                     state_next.ctl.rst = 1'b1;
                     state_next.cnt     = STROBE_CYC;
                     state_next.seq     = ST_STROBE;
                  end
                  default:
                  begin
                     state_next.op = OP_NONE;
                  end
               endcase
            end
         end
         ST_SETUP:
         begin
            if (state_reg.cnt > 8'h01)
            begin
               state_next.cnt = state_reg.cnt - 8'h01;
            end
            else
            begin
               state_next.ctl.cs_n = 1'b0;
               state_next.cnt      = (state_reg.op == OP_READ) ? read_hold : STROBE_CYC;
               state_next.seq      = ST_STROBE;
            end
         end
         ST_STROBE:
         begin
            if (state_reg.cnt > 8'h01)
            begin
               state_next.cnt = state_reg.cnt - 8'h01;
            end
            else
            begin
               // Sampling the second stage keeps a changing bus away from logic.
               if (state_reg.op == OP_READ)
               begin
                  state_next.rbuf = state_reg.sync2;
               end
               state_next.ctl.cs_n               = 1'b1;
               state_next.ctl.load_output_strobe = 1'b0;
               state_next.ctl.rst                = 1'b0;
               state_next.cnt                    = RECOV_CYC;
               state_next.seq                    = ST_RECOVER;
            end
         end
         ST_RECOVER:
         begin
            if (state_reg.cnt > 8'h01)
            begin
               state_next.cnt = state_reg.cnt - 8'h01;
            end
            else
            begin
               state_next.doe    = 1'b0;
               state_next.ctl.rw = 1'b0;
               state_next.seq    = ST_IDLE;
            end
         end
      endcase

      // Until software says the supplies are up every pin toward the converter is low.
      if (!state_next.en)
      begin
         state_next.ctl  = '0;
         state_next.dout = 16'h0000;
         state_next.doe  = 1'b0;
         state_next.seq  = ST_IDLE;
      end
      else if (!state_reg.en)
      begin
         state_next.ctl.cs_n = 1'b1;           // Idle: chip select high, read/write low.
      end
   end

   // Single state register; reset leaves all converter pins low.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg        <= '0;
         state_reg.pd_cnt <= PD_EXIT_CYC;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs come straight from the state register.
   assign wb_ack_o  = state_reg.ack;
   assign wb_dat_o  = state_reg.rdat;
   assign ctl_o     = state_reg.ctl;
   assign data_o    = state_reg.dout;
   assign data_oe_o = state_reg.doe;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Dropping the enable also ends a strobe, because every pin is then pulled low on purpose.
   sequence seq_strobe_done;
      ##[1:40] (ctl_o.cs_n || !state_reg.en);
   endsequence

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
   // Pins forced low by a cleared enable are not a strobe, so the enable gates these checks.
   chk_write_drive: assert property ($fell(ctl_o.cs_n) && !ctl_o.rw && state_reg.en
                                     |-> data_oe_o)
      else $error("write strobe without data driven");
   chk_write_data_hold: assert property (state_reg.en && !ctl_o.cs_n && !ctl_o.rw
                                         |-> $stable(data_o))
      else $error("write data moved during chip select");
   chk_write_strobe_ends: assert property ($fell(ctl_o.cs_n) |-> seq_strobe_done)
      else $error("chip select never returned high");
   chk_read_release: assert property (ctl_o.rw |-> !data_oe_o)
      else $error("host drives bus during read");
   chk_sel_stable: assert property (state_reg.en && !ctl_o.cs_n
                                    |-> $stable(ctl_o.channel_sel_msb)
                                    && $stable(ctl_o.channel_sel_lsb))
      else $error("channel select moved during strobe");
   chk_pins_low_off: assert property (!state_reg.en |-> ctl_o == '0 && !data_oe_o)
      else $error("pin driven while interface disabled");
   chk_pd_exit_wait: assert property ($rose(ctl_o.power_down_n)
                                      |-> (!state_reg.valid)[*8])
      else $error("outputs flagged valid too early");
   chk_valid_pd: assert property (!ctl_o.power_down_n |=> !state_reg.valid)
      else $error("valid while powered down");
   chk_load_pulse: assert property ($rose(ctl_o.load_output_strobe)
                                    |-> ##[1:40] !ctl_o.load_output_strobe)
      else $error("load strobe never fell");
   chk_rst_pulse: assert property ($rose(ctl_o.rst) |-> ctl_o.cs_n ##[1:40] !ctl_o.rst)
      else $error("reset pulse malformed");

   // An idle, enabled interface keeps chip select high, so no stray strobe reaches the pins.
   chk_idle_cs_high: assert property (!busy && state_reg.en |-> ctl_o.cs_n)
      else $error("chip select low while idle");

   // The reset pulse never overlaps a strobe, so it cannot rewrite an input register.
   chk_rst_no_strobe: assert property (ctl_o.rst |-> ctl_o.cs_n)
      else $error("reset pulse overlaps chip select");

   // The load pulse stands alone as well, so the moved contents are the settled ones.
   chk_load_no_strobe: assert property (ctl_o.load_output_strobe |-> ctl_o.cs_n)
      else $error("load pulse overlaps chip select");

   // Outputs turn valid only after the pin has stayed high through the exit wait.
   chk_valid_late: assert property ($rose(state_reg.valid)
                                    |-> $past(ctl_o.power_down_n, 8))
      else $error("outputs valid before exit wait");

   // Every new request is answered in the cycle after it is taken.
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered");

endmodule

/* src/dac_host_pkg.sv */
// Types shared by the converter host controller.
// Assumes the constants header is included wherever these types meet numbers.
package dac_host_pkg;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SETUP   = 2'b01,
      ST_STROBE  = 2'b10,
      ST_RECOVER = 2'b11
   } seq_state_t;

   typedef enum logic [2:0] {
      OP_NONE  = 3'b000,
      OP_WRITE = 3'b001,
      OP_READ  = 3'b010,
      OP_LOAD  = 3'b011,
      OP_RESET = 3'b100
   } dac_op_t;

   // Control pins toward the converter, all driven by the host.
   typedef struct packed {
      logic       cs_n;
      logic       rw;
      logic       load_output_strobe;
      logic       rst;
      logic       power_down_n;
      logic       channel_sel_msb;
      logic       channel_sel_lsb;
   } dac_ctl_t;

   typedef struct packed {
      logic              ack;
      logic [31:0]       rdat;
      seq_state_t        seq;
      dac_op_t           op;
      logic [1:0]        chan;
      logic [15:0]       wdata;
      logic [15:0]       rbuf;
      logic [7:0]        cnt;
      logic [7:0]        pd_cnt;
      logic              valid;
      logic              en;
      dac_ctl_t          ctl;
      logic [15:0]       dout;
      logic              doe;
      logic [15:0]       sync1;
      logic [15:0]       sync2;
   } host_state_t;
endpackage

/* tb/dac_device_model.sv */
// Behavioural model of the quad converter as seen from its parallel pins.
// Assumes the host drives every pin from the same clock that this model samples.
`timescale 1ns/100ps
module dac_device_model
   import dac_host_pkg::*;
(
   input  wire logic             clk_i,
   input  wire dac_ctl_t         ctl_i,
   input  wire logic [15:0]      bus_i,
   output logic      [15:0]      drive_o,
   output logic [3:0][15:0]      vout_o,
   output logic                  hiz_o
);
   logic [3:0][15:0] in_reg;
   logic [1:0]       cs_s;
   logic [1:0]       ld_s;
   logic [1:0]       rs_s;
   logic [1:0]       chan;

   // Outputs start at zero and stay there until a write and load replace them.
   initial
   begin
      in_reg = '0;
      vout_o = '0;
      drive_o = 16'h0000;
      cs_s = 2'b00;
      ld_s = 2'b00;
      rs_s = 2'b00;
   end

   // Channel code and power-down mode come straight from the pins.
   assign chan = {ctl_i.channel_sel_msb, ctl_i.channel_sel_lsb};
   assign hiz_o = ~ctl_i.power_down_n;

   // Pin edges are detected once each; power-down never touches the registers.
   always @(posedge clk_i)
   begin
      cs_s <= {cs_s[0], ctl_i.cs_n};
      ld_s <= {ld_s[0], ctl_i.load_output_strobe};
      rs_s <= {rs_s[0], ctl_i.rst};
      if (cs_s[1] && !cs_s[0] && !ctl_i.rw)
         in_reg[chan] <= bus_i;
      if (!ld_s[1] && ld_s[0])
         vout_o <= in_reg;
      if (!rs_s[1] && rs_s[0])
         vout_o <= '0;
      // A released bus toggles so that a stale value can never pass for data.
      if (!ctl_i.cs_n && ctl_i.rw)
         drive_o <= in_reg[chan];
      else
         drive_o <= ~drive_o;
   end
endmodule

/* tb/test_quad_dac_reset_powerdown_ctrl.sv */
// Self-checking bench of the converter host controller against a pin-level converter model.
// Assumes the package, the constants header and the converter model are compiled first.
`timescale 1ns/100ps
`include "dac_host_consts.svh"
module test_quad_dac_reset_powerdown_ctrl
   import dac_host_pkg::*;
;
   logic             clk_i;
   logic             rst_i;
   logic             wb_cyc;
   logic             wb_stb;
   logic             wb_we;
   logic [7:0]       wb_adr;
   logic [31:0]      wb_dat;
   logic [31:0]      wb_dat_o;
   logic             wb_ack_o;
   dac_ctl_t         ctl_o;
   logic [15:0]      data_o;
   logic             data_oe_o;
   logic [15:0]      data_i;
   logic [3:0][15:0] vout;
   logic             hiz;
   logic [15:0]      vals [4] = '{16'hFFFF, 16'h0000, 16'h8001, 16'h5A3C};
   int               errors;
   int               comparisons;
   int               cycles;
   int               start;

   // The exit delay is shortened so the power-down test stays brief.
   dac_host_ctrl #(.PD_EXIT_CYC(8'h08)) dac_host_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ctl_o(ctl_o), .data_o(data_o), .data_oe_o(data_oe_o),
      .data_i(data_i));

   dac_device_model dac_device_model_inst (
      .clk_i(clk_i), .ctl_i(ctl_o), .bus_i(data_o), .drive_o(data_i), .vout_o(vout),
      .hiz_o(hiz));

   // Free-running 40 MHz clock and a cycle count for delay measurements.
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cycles <= cycles + 1;

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [63:0] act, input logic [63:0] exp, input string what);
      comparisons++;
      if (act !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, act, exp);
      end
   endtask

   // One classic cycle; the request holds until ack is sampled high.
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] r);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      r = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      check(wb_ack_o, 1'b1, "bus answer");
      if (wb_ack_o !== 1'b1)
         stop_test();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb_cycle(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      wb_cycle(1'b0, a, 32'h0, r);
      check(r, exp, what);
   endtask

   // Polls status until the chosen bit reaches the wanted level, with a bound.
   task automatic wait_bit(input int b, input logic lvl);
      logic [31:0] r;
      int n;
      n = 0;
      do
      begin
         wb_cycle(1'b0, `DAC_OFS_STATUS, 32'h0, r);
         n++;
      end
      while (r[b] !== lvl && n < 40);
      check(r[b], lvl, "status wait");
      if (r[b] !== lvl)
         stop_test();
   endtask

   task automatic cmd(input dac_op_t op, input logic [1:0] ch);
      wr(`DAC_OFS_CMD, {27'h0, op, ch});
      wait_bit(`DAC_STAT_BUSY, 1'b0);
   endtask

   // Main sequence: reset, write and read all channels, load, reset, power-down.
   initial
   begin
      errors = 0;
      comparisons = 0;
      rst_i = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_dat = 32'h0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(ctl_o, 7'h00, "pins after reset");
      check(data_oe_o, 1'b0, "bus drive after reset");
      check(vout, 64'h0, "outputs at power-up");
      rd(8'h40, 32'h0, "unmapped read");
      $display("Test 1 done: idle after reset");
      wr(`DAC_OFS_CTRL, 32'h3);
      for (int c = 0; c < 4; c++)
      begin
         wr(`DAC_OFS_DATA, {16'h0, vals[c]});
         cmd(OP_WRITE, 2'(c));
      end
      for (int c = 0; c < 4; c++)
      begin
         cmd(OP_READ, 2'(c));
         rd(`DAC_OFS_RDATA, {16'h0, vals[c]}, "readback");
      end
      check(vout, 64'h0, "outputs before load");
      $display("Test 2 done: write and readback");
      cmd(OP_LOAD, 2'b00);
      check(vout, {vals[3], vals[2], vals[1], vals[0]}, "outputs after load");
      cmd(OP_RESET, 2'b00);
      check(vout, 64'h0, "outputs after reset pulse");
      cmd(OP_READ, 2'b10);
      rd(`DAC_OFS_RDATA, {16'h0, vals[2]}, "input kept over reset");
      rd(`DAC_OFS_CMD, 32'h0000_000A, "last command");
      rd(`DAC_OFS_DATA, {16'h0, vals[3]}, "data register");
      wr(`DAC_OFS_CMD, 32'h0000_001D);
      rd(`DAC_OFS_CMD, 32'h0000_0001, "unknown op dropped");
      check(vout, 64'h0, "no action on unknown op");
      $display("Test 3 done: load and reset");
      cmd(OP_LOAD, 2'b00);
      wr(`DAC_OFS_CTRL, 32'h2);
      @(posedge clk_i);
      check(hiz, 1'b1, "power-down mode");
      rd(`DAC_OFS_CTRL, 32'h0000_0002, "pin level register");
      rd(`DAC_OFS_STATUS, 32'h0, "not valid while down");
      wr(`DAC_OFS_CTRL, 32'h3);
      start = cycles;
      rd(`DAC_OFS_STATUS, 32'h0, "not valid during exit");
      wait_bit(`DAC_STAT_VALID, 1'b1);
      check(cycles - start >= 8, 1'b1, "exit delay length");
      check(hiz, 1'b0, "normal mode");
      check(vout, {vals[3], vals[2], vals[1], vals[0]}, "outputs kept");
      $display("Test 4 done: power-down");
      stop_test();
   end
endmodule
